/* File: ccss_clock_regs.vh */
// Constants for the core clock speed select block.
// Assumes it is included by bare name into every design file that needs it.
`ifndef CCSS_CLOCK_REGS_VH
`define CCSS_CLOCK_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CCSS_CLOCK_RATE_CONTROL_ADDR 8'h8F
`define CCSS_CLOCK_RATE_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// Field positions of clock_rate_control
// ----------------------------------------------------------------
`define CCSS_CPU_DOUBLE_SPEED_SEL_BIT 0
`define CCSS_TIMER0_CLOCK_SPEED_SEL_BIT 1
`define CCSS_TIMER1_CLOCK_SPEED_SEL_BIT 2
`define CCSS_TIMER2_CLOCK_SPEED_SEL_BIT 3
`define CCSS_SERIAL_PORT_CLOCK_SPEED_SEL_BIT 4
`define CCSS_COUNTER_ARRAY_CLOCK_SPEED_SEL_BIT 5
`define CCSS_WATCHDOG_CLOCK_SPEED_SEL_BIT 6
`define CCSS_CAN_CLOCK_SPEED_SEL_BIT 7
`define CCSS_PERIPH_COUNT 7

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CCSS_PERIODS_STANDARD 12
`define CCSS_PERIODS_DOUBLE 6
`define CCSS_PHASE_LAST 3'h5
`define CCSS_PHASE_FIRST 3'h0

`endif

/* File: ccss_cycle_gen.v */
// Phase generator: six core clock periods make one machine cycle.
// Assumes tick comes from a flop and is high once per core clock period.
`include "ccss_clock_regs.vh"

module ccss_cycle_gen (
    // Clock and reset
    input wire CLOCK,
    input wire RST_B,
    // Core clock tick
    input wire tick,
    // Outputs
    output reg clk_en,
    output reg cycle_end,
    output reg [2:0] phase
);

    reg [2:0] next_phase;

    // ----------------------------------------------------------------
    // Phase counter
    // ----------------------------------------------------------------
    always @*
    begin
        next_phase = phase;
        if (tick)
        begin
            if (phase == `CCSS_PHASE_LAST)
                next_phase = `CCSS_PHASE_FIRST;
            else
                next_phase = phase + 3'h1;
        end
    end

    always @(posedge CLOCK)
    begin
        if (!RST_B)
        begin
            phase <= `CCSS_PHASE_FIRST;
            clk_en <= 1'b0;
            cycle_end <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            clk_en <= tick;
            cycle_end <= tick && (phase == `CCSS_PHASE_LAST); // [RL1]
        end
    end

endmodule // ccss_cycle_gen

/* File: ccss_clock_speed_select.v */
// Core and peripheral clock rate selection with glitch-free mode change.
// Assumes CLOCK is the crystal clock and the SFR port is synchronous to it.
//
// What this block does
// [RL1] Twelve crystal periods standard, six in double speed
// [RL2] Divide-by-two stage, software bypass for double speed
// [RL3] Reset starts standard speed unless fuse set
// [RL4] Programmed fuse starts double speed after reset
// [RL5] Bit zero switches the CPU clock and every peripheral whose bit is cleared
// [RL6] Peripheral doubles only while its bit is cleared
// [RL7] Speed bit change applied at divided rising edge
// [RL8] Peripheral bit ignored while CPU speed low
// [RL9] Control register resets to all zeros
// [RL10] Peripheral bit changes also applied at divided edge
`include "ccss_clock_regs.vh"

module ccss_clock_speed_select (
    // Clock and reset
    input wire CLOCK,
    input wire RST_B,
    // Non-volatile start option
    input wire BOOT_FAST_MODE_FUSE,
    // SFR access port
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_WDATA,
    output reg [7:0] SFR_RDATA,
    // Divided crystal clock
    output reg DIV2_CLK,
    // CPU core clock
    output wire CPU_CLK_EN,
    output wire CPU_MACHINE_CYCLE,
    output wire STANDARD_SPEED_MODE,
    // Peripheral clocks: bit 0 timer0 up to bit 6 CAN
    output wire [6:0] PERIPH_CLK_EN,
    output wire [6:0] PERIPH_CYCLE,
    output reg [6:0] PERIPH_DOUBLE
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [7:0] clock_rate_control;
    reg [7:0] next_clock_rate_control;
    reg [7:0] applied;
    reg boot_done;
    reg cpu_tick;
    reg [6:0] periph_tick;
    wire div_rise;
    wire sfr_hit;
    wire cpu_double_speed_sel;
    wire [6:0] periph_sel;

    assign sfr_hit = (SFR_ADDR == `CCSS_CLOCK_RATE_CONTROL_ADDR);
    // Divided clock rises at the next edge while it is low
    assign div_rise = !DIV2_CLK;
    assign cpu_double_speed_sel = applied[`CCSS_CPU_DOUBLE_SPEED_SEL_BIT];
    assign periph_sel = applied[7:1];
    assign STANDARD_SPEED_MODE = !cpu_double_speed_sel;

    // ----------------------------------------------------------------
    // Divide-by-two stage
    // ----------------------------------------------------------------
    // Runs always so the mode change has a reference edge to wait for
    always @(posedge CLOCK)
    begin
        if (!RST_B)
            DIV2_CLK <= 1'b0;
        else
            DIV2_CLK <= !DIV2_CLK; // [RL2]
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always @*
    begin
        next_clock_rate_control = clock_rate_control;
        if (!boot_done)
        begin
            // Fuse is caught once, at the first edge after reset release
            next_clock_rate_control[`CCSS_CPU_DOUBLE_SPEED_SEL_BIT] = BOOT_FAST_MODE_FUSE; // [RL4]
        end
        else if (SFR_WR && sfr_hit)
        begin
            next_clock_rate_control = SFR_WDATA;
        end
    end

    always @(posedge CLOCK)
    begin
        if (!RST_B)
        begin
            clock_rate_control <= `CCSS_CLOCK_RATE_CONTROL_RESET; // [RL9]
            boot_done <= 1'b0;
            SFR_RDATA <= 8'h00;
        end
        else
        begin
            clock_rate_control <= next_clock_rate_control;
            boot_done <= 1'b1;
            if (SFR_RD && sfr_hit)
                SFR_RDATA <= clock_rate_control;
            else
                SFR_RDATA <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Synchronised mode change
    // ----------------------------------------------------------------
    // Taking the new bits only at the divided rising edge means a core
    // period is never cut short when the divider is bypassed or restored
    always @(posedge CLOCK)
    begin
        if (!RST_B)
            applied <= `CCSS_CLOCK_RATE_CONTROL_RESET; // [RL3]
        else if (div_rise)
        begin
            applied[`CCSS_CPU_DOUBLE_SPEED_SEL_BIT] <=
                clock_rate_control[`CCSS_CPU_DOUBLE_SPEED_SEL_BIT]; // [RL7]
            applied[7:1] <= clock_rate_control[7:1]; // [RL10]
        end
    end

    // ----------------------------------------------------------------
    // Core clock
    // ----------------------------------------------------------------
    // Standard speed ticks at divided rising edges, double speed every edge
    always @(posedge CLOCK)
    begin
        if (!RST_B)
            cpu_tick <= 1'b0;
        else
            cpu_tick <= cpu_double_speed_sel || div_rise; // [RL1] [RL5]
    end

    ccss_cycle_gen u_cpu_gen (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .tick(cpu_tick),
        .clk_en(CPU_CLK_EN),
        .cycle_end(CPU_MACHINE_CYCLE),
        .phase()
    );

    // ----------------------------------------------------------------
    // Peripheral clocks
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CCSS_PERIPH_COUNT; g = g + 1)
        begin : g_periph
            always @(posedge CLOCK)
            begin
                if (!RST_B)
                begin
                    periph_tick[g] <= 1'b0;
                    PERIPH_DOUBLE[g] <= 1'b0;
                end
                else
                begin
                    // Selection bit only counts while the CPU runs double
                    PERIPH_DOUBLE[g] <= cpu_double_speed_sel && !periph_sel[g]; // [RL6] [RL8]
                    periph_tick[g] <= (cpu_double_speed_sel && !periph_sel[g])
                        || div_rise; // [RL8]
                end
            end

            ccss_cycle_gen u_periph_gen (
                .CLOCK(CLOCK),
                .RST_B(RST_B),
                .tick(periph_tick[g]),
                .clk_en(PERIPH_CLK_EN[g]),
                .cycle_end(PERIPH_CYCLE[g]),
                .phase()
            );
        end
    endgenerate

endmodule // ccss_clock_speed_select

/* File: ccss_clock_checker_assertions.sv */
// Checker for the clock speed select block, bound to its top ports.
// Assumes a single crystal clock domain with synchronous active-low reset.
module ccss_clock_checker (
    // Clock and reset
    input logic CLOCK,
    input logic RST_B,
    // Clock outputs
    input logic DIV2_CLK,
    input logic CPU_CLK_EN,
    input logic CPU_MACHINE_CYCLE,
    input logic STANDARD_SPEED_MODE,
    input logic [6:0] PERIPH_CLK_EN,
    input logic [6:0] PERIPH_DOUBLE
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // Ticks lag the applied bit by two edges, so the mode two edges back decides
    chk_normal_tick_gap:
    assert property (CPU_CLK_EN && $past(STANDARD_SPEED_MODE) && $past(STANDARD_SPEED_MODE, 2)
        |=> !CPU_CLK_EN)
        else $error("Core ticks in consecutive cycles at standard speed");
    chk_double_rate:
    assert property (!STANDARD_SPEED_MODE && !$past(STANDARD_SPEED_MODE, 2) |-> CPU_CLK_EN)
        else $error("Core tick missing in double speed");
    chk_cycle_on_tick:
    assert property (CPU_MACHINE_CYCLE |-> CPU_CLK_EN)
        else $error("Machine cycle end without core tick");
    chk_speed_sync_edge:
    assert property ($changed(STANDARD_SPEED_MODE) |-> !$past(DIV2_CLK))
        else $error("Speed mode changed off the divided edge");
    chk_periph_hold:
    assert property ($changed(PERIPH_DOUBLE) |=> $stable(PERIPH_DOUBLE))
        else $error("Peripheral rate changed at two edges in a row");
    chk_periph_normal_off:
    assert property (STANDARD_SPEED_MODE && $past(STANDARD_SPEED_MODE) |-> PERIPH_DOUBLE == 7'h00)
        else $error("Peripheral doubled while core in standard speed");
    chk_div2_toggle:
    assert property ($past(RST_B) |-> DIV2_CLK != $past(DIV2_CLK))
        else $error("Divided clock failed to toggle");
    chk_periph_double_rate:
    assert property (PERIPH_DOUBLE[0] && $past(PERIPH_DOUBLE[0]) |-> PERIPH_CLK_EN[0])
        else $error("Timer0 tick missing at double rate");
endmodule // ccss_clock_checker

bind ccss_clock_speed_select ccss_clock_checker u_chk (.CLOCK(CLOCK), .RST_B(RST_B),
    .DIV2_CLK(DIV2_CLK), .CPU_CLK_EN(CPU_CLK_EN), .CPU_MACHINE_CYCLE(CPU_MACHINE_CYCLE),
    .STANDARD_SPEED_MODE(STANDARD_SPEED_MODE), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .PERIPH_DOUBLE(PERIPH_DOUBLE));

/* File: core_clock_speed_select_test.sv */
// Bench for the clock speed select block: register access and tick counts.
// Assumes the design and its checker are compiled alongside.
module core_clock_speed_select_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rst_b = 0, fuse = 0, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire [7:0] rdata;
    wire div2, cpu_en, cpu_cyc, norm_mode;
    wire [6:0] p_en, p_cyc, p_dbl;
    int bad_count = 0, total_checks = 0, n_cpu, n_cyc, n_per, n_pcy;
    initial forever #2 clock = ~clock;
    ccss_clock_speed_select DUT (.CLOCK(clock), .RST_B(rst_b), .BOOT_FAST_MODE_FUSE(fuse),
        .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .DIV2_CLK(div2), .CPU_CLK_EN(cpu_en), .CPU_MACHINE_CYCLE(cpu_cyc),
        .STANDARD_SPEED_MODE(norm_mode), .PERIPH_CLK_EN(p_en), .PERIPH_CYCLE(p_cyc),
        .PERIPH_DOUBLE(p_dbl));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task check(string name, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One strobe cycle; read data is settled just after the taking edge
    task sfr_access(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task count_ticks(int n);
        n_cpu = 0;
        n_cyc = 0;
        n_per = 0;
        n_pcy = 0;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            n_cpu += cpu_en;
            n_cyc += cpu_cyc;
            n_per += p_en[0];
            n_pcy += p_cyc[6];
        end
    endtask
    // Settling cycles cover the divided-edge sync and the tick pipeline
    task write_settle(logic [7:0] d);
        sfr_access(1'b1, 8'h8F, d);
        count_ticks(6);
        count_ticks(24);
    endtask
    task do_reset(logic f);
        @(posedge clock);
        rst_b <= 1'b0;
        fuse <= f;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task report_and_stop();
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        do_reset(1'b0);
        check("normal mode", norm_mode, 8'h01);
        sfr_access(1'b0, 8'h8F, 8'h00);
        check("reset value", rdata, 8'h00);
        count_ticks(24);
        check("normal ticks", n_cpu, 8'h0C);
        check("normal cycles", n_cyc, 8'h02);
        check("normal periph", n_per, 8'h0C);
        check("normal periph cycles", n_pcy, 8'h02);
        write_settle(8'h01);
        check("fast ticks", n_cpu, 8'h18);
        check("fast cycles", n_cyc, 8'h04);
        check("fast periph", n_per, 8'h18);
        check("fast periph cycles", n_pcy, 8'h04);
        check("fast double", p_dbl, 8'h7F);
        write_settle(8'hFF);
        check("cpu only ticks", n_cpu, 8'h18);
        check("cpu only periph", n_per, 8'h0C);
        check("cpu only periph cycles", n_pcy, 8'h02);
        for (int i = 0; i < 7; i++)
        begin
            sfr_access(1'b1, 8'h8F, 8'h01 | (8'h02 << i));
            count_ticks(6);
            check("per bit double", p_dbl, ~(8'h01 << i) & 8'h7F);
        end
        sfr_access(1'b0, 8'h8F, 8'h00);
        check("readback", rdata, 8'h81);
        write_settle(8'hFE);
        check("normal again ticks", n_cpu, 8'h0C);
        check("normal again double", p_dbl, 8'h00);
        sfr_access(1'b1, 8'h8E, 8'h01);
        count_ticks(6);
        check("other addr write", norm_mode, 8'h01);
        sfr_access(1'b0, 8'h8E, 8'h00);
        check("other addr read", rdata, 8'h00);
        do_reset(1'b1);
        check("fuse mode", norm_mode, 8'h00);
        sfr_access(1'b0, 8'h8F, 8'h00);
        check("fuse readback", rdata, 8'h01);
        report_and_stop();
    end
    initial
    begin
        #20000;
        bad_count++;
        report_and_stop();
    end
endmodule // core_clock_speed_select_test
